// File: hdl/sarcc_top.sv
// Conversion control logic of a 10-bit successive-approximation converter.
// Assumes start, enables and comparator arrive asynchronously from pins.
// What this block does
// - While start is high the top result bit is set and the rest cleared.
// - Trials begin when start falls; start must be high 500 ns first.
// - A new start during a conversion restarts the whole sequence.
// - The top decision comes two conversion clocks plus 200 ns after start.
// - Each later decision comes one conversion clock after the last one.
// - A high comparator clears the trial bit, then the next bit is tried.
// - The result stays latched until a new conversion starts.
// - Short-cycle low ends after 8 decisions, high runs all 10.
// - High-byte enable low floats bits 9 and 8, high drives them.
// - Low-byte enable high drives bits 7 to 0, low floats them.
// - Status floats when its enable is low, else low busy, high done.
// - The serial output shows each decision and floats when idle.
// - The bit strobe gives 10 rising edges per conversion, else floats.
// - The internal clock runs only in a conversion, external runs free.
`timescale 1ns/1ns
module sarcc_top #(
   parameter int CONV_DIV = sarcc_pkg::CONV_DIV_DEFAULT
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst_n,
   // Converter pins.
   input wire logic convert_start,
   input wire logic high_byte_enable,
   input wire logic low_byte_enable,
   input wire logic status_output_enable,
   input wire logic short_cycle_select,
   input wire logic comp_below,
   // Three-state outputs.
   output sarcc_pkg::sarcc_pins_t pins,
   // Register port.
   input wire sarcc_pkg::sarcc_bus_t bus,
   output logic [31:0] rdata,
   // Interrupt.
   output logic irq
);

   // Synchroniser stages for pin inputs.
   logic [5:0] meta_r;
   logic [5:0] sync_r;
   logic start_s;
   logic high_byte_enable_s;
   logic low_byte_enable_s;
   logic sten_s;
   logic sc_s;
   logic comp_s;
   logic start_d_r;
   logic start_fall;
   logic start_rise;

   // Sequencer state.
   sarcc_pkg::sarcc_state_t state_r;
   logic [9:0] result_r;
   logic [9:0] trial_r;
   logic [3:0] bits_r;
   logic [1:0] lead_r;
   logic [4:0] settle_r;
   logic pend_r;
   logic [15:0] hold_r;
   logic decide;
   logic busy;
   logic [3:0] nbits;

   // Software registers.
   logic [1:0] ctrl_r;
   logic [1:0] irq_stat_r;
   logic [1:0] irq_mask_r;
   logic [1:0] irq_set;
   logic tick;

   // Serial outputs.
   logic serial_r;
   logic strobe_r;
   logic [3:0] edges_r;

   // Two flip-flops on every pin input; only stage two is read.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= 6'h00;
         sync_r <= 6'h00;
      end else begin
         meta_r <= {comp_below, short_cycle_select, status_output_enable,
                    low_byte_enable, high_byte_enable, convert_start};
         sync_r <= meta_r;
      end
   end

   assign start_s = sync_r[0];
   assign high_byte_enable_s = sync_r[1];
   assign low_byte_enable_s = sync_r[2];
   assign sten_s = sync_r[3];
   assign sc_s = sync_r[4];
   assign comp_s = sync_r[5];

   // Start edge detection.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         start_d_r <= 1'b0;
      end else begin
         start_d_r <= start_s;
      end
   end

   assign start_fall = start_d_r && !start_s;
   assign start_rise = start_s && !start_d_r;
   assign busy = (state_r != sarcc_pkg::SARCC_DONE) &&
                 (state_r != sarcc_pkg::SARCC_IDLE);
   assign nbits = sc_s ? 4'(sarcc_pkg::FULL_BITS)
                       : 4'(sarcc_pkg::SHORT_BITS);

   // Conversion clock: gated to the conversion when internal is chosen.
   sarcc_clkgen #(
      .DIV(CONV_DIV)
   ) u_clkgen (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .run(busy),
      .gated(ctrl_r[sarcc_pkg::CTRL_INTCLK_BIT]),
      .tick(tick)
   );

   // Settle delay after each conversion clock before the latch is clocked.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         settle_r <= 5'h00;
         pend_r <= 1'b0;
      end else if (state_r != sarcc_pkg::SARCC_TRIAL) begin
         settle_r <= 5'h00;
         pend_r <= 1'b0;
      end else if (tick) begin
         settle_r <= 5'(sarcc_pkg::SETTLE_CYC);
         pend_r <= 1'b1;
      end else if (pend_r && settle_r != 5'h00) begin
         settle_r <= settle_r - 5'h01;
      end else begin
         pend_r <= 1'b0;
      end
   end

   assign decide = pend_r && (settle_r == 5'h00);

   // Start-width counter, used to flag a too-short start pulse.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_r <= 16'h0000;
      end else if (start_s) begin
         if (hold_r != 16'hffff) begin
            hold_r <= hold_r + 16'h0001;
         end
      end else begin
         hold_r <= 16'h0000;
      end
   end

   // Sequencer: hold while start high, lead-in, trials, then done.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= sarcc_pkg::SARCC_IDLE;
         result_r <= sarcc_pkg::RESULT_RESET;
         trial_r <= sarcc_pkg::RESULT_RESET;
         bits_r <= 4'h0;
         lead_r <= 2'h0;
      end else if (start_s) begin
         state_r <= sarcc_pkg::SARCC_HOLD;
         result_r <= sarcc_pkg::TRIAL_START;
         trial_r <= sarcc_pkg::TRIAL_START;
         bits_r <= 4'h0;
         lead_r <= 2'h0;
      end else begin
         case (state_r)
            sarcc_pkg::SARCC_HOLD: begin
               if (start_fall) begin
                  state_r <= sarcc_pkg::SARCC_LEAD;
               end
            end
            sarcc_pkg::SARCC_LEAD: begin
               // One extra clock ahead of the first trial window.
               if (tick) begin
                  lead_r <= lead_r + 2'h1;
                  state_r <= sarcc_pkg::SARCC_TRIAL;
               end
            end
            sarcc_pkg::SARCC_TRIAL: begin
               if (decide) begin
                  if (comp_s) begin
                     result_r <= (result_r & ~trial_r) | (trial_r >> 1);
                  end else begin
                     result_r <= result_r | (trial_r >> 1);
                  end
                  trial_r <= trial_r >> 1;
                  bits_r <= bits_r + 4'h1;
                  if (bits_r + 4'h1 == nbits) begin
                     state_r <= sarcc_pkg::SARCC_DONE;
                     result_r <= comp_s ? (result_r & ~trial_r) : result_r;
                  end
               end
            end
            sarcc_pkg::SARCC_DONE: begin
               state_r <= sarcc_pkg::SARCC_DONE;
            end
            sarcc_pkg::SARCC_IDLE: begin
               state_r <= sarcc_pkg::SARCC_IDLE;
            end
            default: begin
               state_r <= sarcc_pkg::SARCC_IDLE;
            end
         endcase
      end
   end

   // Serial decision output and strobe: data set, then strobe rises.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         serial_r <= 1'b0;
         strobe_r <= 1'b0;
         edges_r <= 4'h0;
      end else if (state_r == sarcc_pkg::SARCC_HOLD) begin
         serial_r <= 1'b0;
         strobe_r <= 1'b0;
         edges_r <= 4'h0;
      end else if (decide) begin
         serial_r <= !comp_s;
         strobe_r <= 1'b0;
      end else if (pend_r == 1'b0 && state_r == sarcc_pkg::SARCC_TRIAL &&
                   edges_r < bits_r) begin
         strobe_r <= 1'b1;
         edges_r <= edges_r + 4'h1;
      end else if (state_r == sarcc_pkg::SARCC_DONE &&
                   edges_r < 4'(sarcc_pkg::FULL_BITS)) begin
         // Pad to ten edges; also gives the tenth edge of a full conversion.
         strobe_r <= !strobe_r;
         if (!strobe_r) begin
            edges_r <= edges_r + 4'h1;
         end
      end else if (state_r == sarcc_pkg::SARCC_DONE) begin
         strobe_r <= 1'b0;
      end
   end

   // Output pins, all from flip-flops.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pins <= '0;
      end else begin
         pins.data <= result_r;
         pins.data_oe <= {{2{high_byte_enable_s}}, {8{low_byte_enable_s}}};
         pins.status <= (state_r == sarcc_pkg::SARCC_DONE);
         pins.status_oe <= sten_s;
         pins.serial <= serial_r;
         // Drivers stay on until the last strobe rise has been shown.
         pins.serial_oe <= (busy && (state_r != sarcc_pkg::SARCC_HOLD)) ||
                           (state_r == sarcc_pkg::SARCC_DONE &&
                            (edges_r < 4'(sarcc_pkg::FULL_BITS) ||
                             strobe_r));
         pins.strobe <= strobe_r;
         pins.strobe_oe <= busy || (state_r == sarcc_pkg::SARCC_DONE &&
                           (edges_r < 4'(sarcc_pkg::FULL_BITS) ||
                            strobe_r));
      end
   end

   // Interrupt events: done, and a start released too early.
   assign irq_set[sarcc_pkg::IRQ_DONE_BIT] =
      (state_r == sarcc_pkg::SARCC_TRIAL) && decide &&
      (bits_r + 4'h1 == nbits);
   assign irq_set[sarcc_pkg::IRQ_ABORT_BIT] =
      start_fall && (hold_r < 16'(sarcc_pkg::START_MIN_CYC));

   // Control and mask registers.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= sarcc_pkg::CTRL_RESET;
         irq_mask_r <= 2'h0;
      end else if (bus.wr) begin
         if (bus.addr == sarcc_pkg::REG_CTRL) begin
            ctrl_r <= bus.wdata[1:0];
         end
         if (bus.addr == sarcc_pkg::REG_IRQ_MASK) begin
            irq_mask_r <= bus.wdata[1:0];
         end
      end
   end

   // Sticky status: set wins over a write-one clear.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_r <= 2'h0;
      end else if (bus.wr && bus.addr == sarcc_pkg::REG_IRQ_STAT) begin
         irq_stat_r <= (irq_stat_r & ~bus.wdata[1:0]) | irq_set;
      end else begin
         irq_stat_r <= irq_stat_r | irq_set;
      end
   end

   // Interrupt output.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |((irq_stat_r | irq_set) & irq_mask_r);
      end
   end

   // Read data, valid the cycle after the read strobe.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 32'h0000_0000;
      end else if (bus.rd) begin
         case (bus.addr)
            sarcc_pkg::REG_CTRL: rdata <= {30'h0, ctrl_r};
            sarcc_pkg::REG_RESULT: rdata <= {21'h0, busy, result_r};
            sarcc_pkg::REG_IRQ_STAT: rdata <= {30'h0, irq_stat_r};
            sarcc_pkg::REG_IRQ_MASK: rdata <= {30'h0, irq_mask_r};
            default: rdata <= 32'h0000_0000;
         endcase
      end else begin
         rdata <= 32'h0000_0000;
      end
   end

   // Assertion on the restart behaviour.
   property p_restart;
      @(posedge core_clk) disable iff (!rst_n)
      start_s |=> (result_r == sarcc_pkg::TRIAL_START);
   endproperty
   a_restart: assert property (p_restart) else $error("restart");

   // Output enable follows high-byte enable.
   property p_high_byte_enable;
      @(posedge core_clk) disable iff (!rst_n)
      high_byte_enable_s |=> pins.data_oe[9];
   endproperty
   a_high_byte_enable: assert property (p_high_byte_enable) else $error("high_byte_enable");

   // Result stays latched when done.
   property p_hold;
      @(posedge core_clk) disable iff (!rst_n)
      (state_r == sarcc_pkg::SARCC_DONE && !start_s) |=> $stable(result_r);
   endproperty
   a_hold: assert property (p_hold) else $error("hold");

   // Status reads low while the sequencer is busy.
   property p_status_busy;
      @(posedge core_clk) disable iff (!rst_n)
      busy |=> !pins.status;
   endproperty
   a_status_busy: assert property (p_status_busy) else $error("busy");

   // Status reads high once the conversion is done.
   property p_status_done;
      @(posedge core_clk) disable iff (!rst_n)
      (state_r == sarcc_pkg::SARCC_DONE) |=> pins.status;
   endproperty
   a_status_done: assert property (p_status_done) else $error("done");

   // A falling start moves the held sequencer into the lead-in.
   property p_lead;
      @(posedge core_clk) disable iff (!rst_n)
      (state_r == sarcc_pkg::SARCC_HOLD && start_fall) |=>
         (state_r == sarcc_pkg::SARCC_LEAD);
   endproperty
   a_lead: assert property (p_lead) else $error("lead");

endmodule

// File: pkg/sarcc_pkg.sv
// Package of constants and carrier types for the SAR conversion control.
// Assumes one 100 MHz core clock and a plain register port.
package sarcc_pkg;

   // Core clock period in nanoseconds.
   localparam int CLK_PERIOD_NS = 10;

   // Least start-pulse width before release, in ns and cycles.
   localparam int START_MIN_NS = 500;
   localparam int START_MIN_CYC =
      (START_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Fixed comparator settling delay after each conversion clock edge.
   localparam int SETTLE_NS = 200;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Default conversion clock divider, in core cycles per period.
   localparam int CONV_DIV_DEFAULT = 40;

   // Number of bits in a full and in a short-cycled conversion.
   localparam int FULL_BITS = 10;
   localparam int SHORT_BITS = 8;

   // Reset values.
   localparam logic [9:0] RESULT_RESET = 10'h000;
   localparam logic [9:0] TRIAL_START = 10'h200;

   // Interrupt status and mask layout.
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_ABORT_BIT = 1;
   localparam int IRQ_WIDTH = 2;

   // Register indices on the plain register port.
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_RESULT = 4'h1;
   localparam logic [3:0] REG_IRQ_STAT = 4'h2;
   localparam logic [3:0] REG_IRQ_MASK = 4'h3;

   // Control register bit positions.
   localparam int CTRL_INTCLK_BIT = 0;
   localparam logic [1:0] CTRL_RESET = 2'h0;

   // Sequencer states, one-hot.
   typedef enum logic [4:0] {
      SARCC_IDLE = 5'h01,
      SARCC_HOLD = 5'h02,
      SARCC_LEAD = 5'h04,
      SARCC_TRIAL = 5'h08,
      SARCC_DONE = 5'h10
   } sarcc_state_t;

   // Three-state pin carrier: value and enable.
   typedef struct packed {
      logic [9:0] data;
      logic [9:0] data_oe;
      logic status;
      logic status_oe;
      logic serial;
      logic serial_oe;
      logic strobe;
      logic strobe_oe;
   } sarcc_pins_t;

   // Software register port carrier.
   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } sarcc_bus_t;

endpackage

// File: hdl/sarcc_clkgen.sv
// Conversion clock generator for the SAR conversion control.
// Assumes the core clock; produces one-cycle tick pulses per period.
`timescale 1ns/1ns
module sarcc_clkgen #(
   parameter int DIV = 40
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst_n,
   // Control.
   input wire logic run,
   input wire logic gated,
   // Tick output.
   output logic tick
);

   logic [15:0] cnt_r;

   // A gated clock restarts its phase at each run, a free one never stops.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 16'h0000;
         tick <= 1'b0;
      end else if (gated && !run) begin
         cnt_r <= 16'h0000;
         tick <= 1'b0;
      end else if (cnt_r == 16'(DIV - 1)) begin
         cnt_r <= 16'h0000;
         tick <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 16'h0001;
         tick <= 1'b0;
      end
   end

endmodule

// File: sim/sarcc_comp_model.sv
// Comparator model facing the SAR conversion control.
// Assumes the byte enables stay high so the trial word is visible.
`timescale 1ns/1ns
module sarcc_comp_model #(
   parameter int DELAY_NS = 30
) (
   // Converter side.
   input wire sarcc_pkg::sarcc_pins_t pins,
   input wire logic [9:0] ain,
   // Comparator decision.
   output logic comp_below
);
   // Reports the input below the trial level after a settling delay.
   assign #(DELAY_NS) comp_below = (ain < pins.data);
endmodule

// File: sim/tb_sarcc_top.sv
// Self-checking testbench of the SAR conversion control.
// Assumes the comparator model and the default conversion clock divider of 40.
`timescale 1ns/1ns
module tb_sarcc_top;
   localparam int DIV = 40;
   logic core_clk;
   logic rst_n;
   logic convert_start;
   logic high_byte_enable;
   logic low_byte_enable;
   logic status_output_enable;
   logic short_cycle_select;
   logic comp_below;
   logic [9:0] ain;
   logic [31:0] rdata;
   logic [31:0] rd_val;
   logic irq;
   logic irq_a;
   sarcc_pkg::sarcc_pins_t pins;
   sarcc_pkg::sarcc_bus_t bus;
   int num_errors;
   int samples_checked;

   sarcc_top #(.CONV_DIV(DIV)) dut (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .convert_start(convert_start),
      .high_byte_enable(high_byte_enable),
      .low_byte_enable(low_byte_enable),
      .status_output_enable(status_output_enable),
      .short_cycle_select(short_cycle_select),
      .comp_below(comp_below),
      .pins(pins),
      .bus(bus),
      .rdata(rdata),
      .irq(irq)
   );

   sarcc_comp_model #(.DELAY_NS(30)) cmp (
      .pins(pins),
      .ain(ain),
      .comp_below(comp_below)
   );

   // Free-running core clock of 100 MHz.
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Compares one value and reports a mismatch.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string msg);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg,
                  seen, exp);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic test_done;
      $display("Checks %0d, errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Writes one register in a single strobed cycle.
   task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge core_clk);
      bus.wr <= 1'b0;
   endtask

   // Reads one register; the data stand in the cycle after the strobe.
   task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge core_clk);
      bus.rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   // Runs one conversion, optionally restarted midway, and judges it.
   task automatic convert(input logic [9:0] val, input logic sc,
                          input int restart, input logic [9:0] exp);
      int cyc;
      int rises;
      int nb;
      logic prev;
      logic [9:0] ser;
      nb = sc ? sarcc_pkg::FULL_BITS : sarcc_pkg::SHORT_BITS;
      ain <= val;
      short_cycle_select <= sc;
      for (int k = 0; k <= restart; k++) begin
         @(posedge core_clk);
         convert_start <= 1'b1;
         repeat (sarcc_pkg::START_MIN_CYC + 2) @(posedge core_clk);
         #1;
         check(pins.data, 10'h200, "start word");
         check(pins.status, 1'b0, "busy level");
         @(posedge core_clk);
         convert_start <= 1'b0;
         if (k < restart) begin
            repeat (4 * DIV) @(posedge core_clk);
         end
      end
      cyc = 0;
      rises = 0;
      prev = 1'b0;
      ser = 10'h000;
      while (pins.status !== 1'b1 && cyc < 3000) begin
         @(posedge core_clk);
         #1;
         cyc++;
         if ((pins.strobe & pins.strobe_oe) === 1'b1 && !prev) begin
            rises++;
            ser = {ser[8:0], pins.serial};
            check(pins.serial_oe, 1'b1, "serial driven");
         end
         prev = pins.strobe & pins.strobe_oe;
      end
      if (cyc >= 3000) begin
         num_errors++;
         $display("CHECK FAILED at %0t: conversion never ended", $time);
         test_done();
      end
      check(cyc >= nb * DIV + sarcc_pkg::SETTLE_CYC, 1'b1, "too fast");
      repeat (300) begin
         @(posedge core_clk);
         #1;
         if ((pins.strobe & pins.strobe_oe) === 1'b1 && !prev) begin
            rises++;
            ser = {ser[8:0], pins.serial};
         end
         prev = pins.strobe & pins.strobe_oe;
      end
      #1;
      check(pins.data, exp, "result");
      check(rises, 10, "strobe edges");
      if (sc) begin
         check(ser, exp, "serial word");
      end
      check(pins.serial_oe, 1'b0, "serial floats");
      check(pins.strobe_oe, 1'b0, "strobe floats");
   endtask

   // Walks every combination of the three output enables.
   task automatic enables;
      for (int i = 0; i < 8; i++) begin
         @(posedge core_clk);
         high_byte_enable <= i[2];
         low_byte_enable <= i[1];
         status_output_enable <= i[0];
         repeat (6) @(posedge core_clk);
         #1;
         check(pins.data_oe[9:8], {2{i[2]}}, "high byte");
         check(pins.data_oe[7:0], {8{i[1]}}, "low byte");
         check(pins.status_oe, i[0], "status enable");
      end
   endtask

   // Checks the registers, the done event, masking and clearing.
   task automatic regs(input logic [9:0] exp);
      bus_rd(sarcc_pkg::REG_CTRL, rd_val);
      check(rd_val, 32'h0000_0000, "control reset");
      bus_rd(sarcc_pkg::REG_RESULT, rd_val);
      check(rd_val[9:0], exp, "result register");
      bus_rd(4'hf, rd_val);
      check(rd_val, 32'h0000_0000, "unmapped read");
      bus_wr(sarcc_pkg::REG_IRQ_MASK, 32'h0000_0000);
      bus_rd(sarcc_pkg::REG_IRQ_STAT, rd_val);
      check(rd_val[sarcc_pkg::IRQ_DONE_BIT], 1'b1, "done event");
      irq_a = irq;
      bus_wr(sarcc_pkg::REG_IRQ_MASK, 32'h0000_0003);
      repeat (2) @(posedge core_clk);
      #1;
      check(irq_a ^ irq, 1'b1, "mask gates interrupt");
      bus_wr(sarcc_pkg::REG_IRQ_STAT, 32'h0000_0003);
      repeat (2) @(posedge core_clk);
      #1;
      check(irq, 1'b0, "interrupt cleared");
      bus_rd(sarcc_pkg::REG_IRQ_STAT, rd_val);
      check(rd_val[1:0], 2'h0, "status cleared");
   endtask

   // Main sequence.
   initial begin
      num_errors = 0;
      samples_checked = 0;
      rst_n = 1'b0;
      convert_start = 1'b0;
      high_byte_enable = 1'b1;
      low_byte_enable = 1'b1;
      status_output_enable = 1'b1;
      short_cycle_select = 1'b1;
      ain = 10'h000;
      bus = '0;
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      #1;
      check(pins.data_oe, 10'h000, "reset drivers");
      check(irq, 1'b0, "reset interrupt");
      convert(10'h000, 1'b1, 0, 10'h000);
      convert(10'h3ff, 1'b1, 0, 10'h3ff);
      convert(10'h155, 1'b1, 1, 10'h155);
      convert(10'h2ab, 1'b0, 0, 10'h2a8);
      regs(10'h2a8);
      bus_wr(sarcc_pkg::REG_CTRL, 32'h0000_0001);
      bus_rd(sarcc_pkg::REG_CTRL, rd_val);
      check(rd_val[0], 1'b1, "clock select");
      convert(10'h0f3, 1'b1, 0, 10'h0f3);
      enables();
      test_done();
   end
endmodule
